// ### verilog/awpme_defs.vh
// Constants for the ACPI wake and event control block: register indices,
// field positions, write masks, reset values and delay figures.
// Assumes a 125 MHz system clock and a 32-bit Avalon-MM register port.
`ifndef AWPME_DEFS_VH
`define AWPME_DEFS_VH

// Register indices; byte address is four times the index.
`define AWP_IDX_PLOSS 8'he4
`define AWP_IDX_GRST 8'he5
`define AWP_IDX_PGC 8'he6
`define AWP_IDX_WRO 8'he7
`define AWP_IDX_GEV 8'hf2
`define AWP_IDX_ST1 8'hf3
`define AWP_IDX_ST2 8'hf4
`define AWP_IDX_EN1 8'hf6
`define AWP_IDX_EN2 8'hf7
`define AWP_IDX_ROUTE 8'hfe

// Reset values.
`define AWP_RST_PLOSS 8'h00
`define AWP_RST_GRST 8'h00
`define AWP_RST_PGC 8'h1c
`define AWP_RST_WRO 8'h00
`define AWP_RST_GEV 8'h3e
`define AWP_RST_EN 8'h00
`define AWP_RST_ROUTE 8'h00

// Bits that hold state; the rest read as zero.
`define AWP_MSK_PLOSS 8'h60
`define AWP_MSK_GRST 8'h04
`define AWP_MSK_PGC 8'h9e
`define AWP_MSK_WRO 8'hf9
`define AWP_MSK_ROUTE 8'h77

// Field positions.
`define AWP_GRST_G25 2
`define AWP_PGC_MCOMBO 7
`define AWP_PGC_CASECLR 5
`define AWP_PGC_LAST 4
`define AWP_PGC_ST1FAST 3
`define AWP_PGC_DEL_HI 2
`define AWP_PGC_DEL_LO 1
`define AWP_PGC_TRIG 0
`define AWP_WRO_KS3 7
`define AWP_WRO_KS2 6
`define AWP_WRO_OSKEY 5
`define AWP_WRO_LPULSE 4
`define AWP_WRO_WDTSRC 3
`define AWP_WRO_HMSRC 0
`define AWP_GEV_EN 0
`define AWP_PL_HI 6
`define AWP_PL_LO 5

// Power-loss policy codes.
`define AWP_PL_OFF 2'b00
`define AWP_PL_ON 2'b01
`define AWP_PL_PRIOR 2'b10
`define AWP_PL_FLAG 2'b11

// Second-stage delay codes.
`define AWP_DEL_NONE 2'b00
`define AWP_DEL_32 2'b01
`define AWP_DEL_96 2'b10

// Timing in milliseconds and the clock rate in cycles per millisecond.
`define AWP_CYC_PER_MS 125000
`define AWP_ST1_SLOW_MS 300
`define AWP_ST1_FAST_MS 200
`define AWP_ST2_32_MS 32
`define AWP_ST2_96_MS 96
`define AWP_ST2_250_MS 250
`define AWP_PULSE_MS 500

`endif

// ### verilog/awpme_ctrl.v
// ACPI wake, power-good sequencing and power-management event control.
// Assumes all inputs are synchronous to sys_clk and event inputs pulse
// for one cycle per event; GPIO event inputs are status levels.
`timescale 1ns/10ps
`include "awpme_defs.vh"

// Functional notes
// [R1] Group reset: 0 bus reset, 1 resume reset.
// [R2] Case clear bit pulses, then reads zero.
// [R3] Last-state flag stored: 0 on, 1 off.
// [R4] First stage delay: 300 or 200 ms.
// [R5] Final stage delay: none, 32, 96, 250 ms.
// [R6] Retrigger bit reruns output low to high.
// [R7] Enable third keyboard wake key set.
// [R8] Enable second keyboard wake key set.
// [R9] OS wake key pulses power button.
// [R10] Half-second button pulse on loss return.
// [R11] Watchdog reset: bus reset or power good.
// [R12] Monitor reset: power good or bus reset.
// [R13] Mouse combination key bit drives out.
// [R14] Group one status flags, write-one clear.
// [R15] Group two status flags, write-one clear.
// [R16] Group one enables gate event output.
// [R17] Group two enables gate event output.
// [R18] GPIO events routed to power button.
// [R19] GPIO events routed to event pin.
// [R20] Event pin low on enabled pending event.
// [R21] Loss policy picks state on return.
module awpme_ctrl #(
   parameter [31:0] P_CYC_MS = `AWP_CYC_PER_MS,
   parameter [31:0] P_ST1_SLOW = `AWP_ST1_SLOW_MS * `AWP_CYC_PER_MS,
   parameter [31:0] P_ST1_FAST = `AWP_ST1_FAST_MS * `AWP_CYC_PER_MS,
   parameter [31:0] P_ST2_32 = `AWP_ST2_32_MS * `AWP_CYC_PER_MS,
   parameter [31:0] P_ST2_96 = `AWP_ST2_96_MS * `AWP_CYC_PER_MS,
   parameter [31:0] P_ST2_250 = `AWP_ST2_250_MS * `AWP_CYC_PER_MS,
   parameter [31:0] P_PULSE = `AWP_PULSE_MS * `AWP_CYC_PER_MS
) (
   input wire sys_clk,
   input wire arst_n,
   input wire [9:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [3:0] byteenable,
   output reg [31:0] readdata,
   output reg waitrequest,
   input wire power_good_low_stage,
   input wire lpc_reset_n,
   input wire resume_well_reset_n,
   input wire power_return,
   input wire state_before_loss,
   input wire keyboard_wake_enable,
   input wire os_wake_key,
   input wire [6:0] event_src_one,
   input wire [5:0] event_src_two,
   input wire [2:0] gpio_event,
   output reg power_good_first_stage,
   output reg power_good_out,
   output reg power_button_out_n,
   output reg pme_out_n,
   output reg case_open_clear,
   output reg mouse_combo_key_c,
   output reg key_set_three_enable,
   output reg key_set_two_enable,
   output reg watchdog_reset_n,
   output reg hw_monitor_reset_n,
   output reg gpio_group_reset_n
);

   localparam [1:0] PG_OFF = 2'd0;
   localparam [1:0] PG_ST1 = 2'd1;
   localparam [1:0] PG_ST2 = 2'd2;
   localparam [1:0] PG_ON = 2'd3;

   reg [7:0] ploss;
   reg [7:0] grst;
   reg [7:0] pgc;
   reg [7:0] wro;
   reg [7:0] gev;
   reg [6:0] st1;
   reg [5:0] st2;
   reg [6:0] en1;
   reg [5:0] en2;
   reg [7:0] route;
   reg retrig;
   reg [1:0] pg_state;
   reg [25:0] pg_cnt;
   reg [25:0] pb_cnt;
   reg [2:0] gpio_prev;
   reg [7:0] next_rd;
   reg wr_ok;
   reg loss_on;
   reg pb_start;

   wire [7:0] idx;
   wire [7:0] wbyte;
   wire wr_lane;
   wire [2:0] gpio_rise;

   assign idx = address[9:2];
   assign wbyte = writedata[7:0];
   assign wr_lane = write & ~waitrequest & byteenable[0];

   // True when the current write lands on the given register.
   function hit;
      input [7:0] a;
      input [7:0] i;
      input w;
      begin
         hit = w & (a == i);
      end
   endfunction

   // Second-stage delay length for a delay code.
   function [25:0] st2_len;
      input [1:0] sel;
      begin
         case (sel)
            `AWP_DEL_NONE: st2_len = 26'h0000000;
            `AWP_DEL_32: st2_len = P_ST2_32[25:0];
            `AWP_DEL_96: st2_len = P_ST2_96[25:0];
            default: st2_len = P_ST2_250[25:0];
         endcase
      end
   endfunction

   // Read multiplexer; unmapped indices read as zero.
   always @* begin
      case (idx)
         `AWP_IDX_PLOSS: next_rd = ploss;
         `AWP_IDX_GRST: next_rd = grst;
         `AWP_IDX_PGC: next_rd = pgc;
         `AWP_IDX_WRO: next_rd = wro;
         `AWP_IDX_GEV: next_rd = gev;
         `AWP_IDX_ST1: next_rd = {1'b0, st1};
         `AWP_IDX_ST2: next_rd = {2'b00, st2};
         `AWP_IDX_EN1: next_rd = {1'b0, en1};
         `AWP_IDX_EN2: next_rd = {2'b00, en2};
         `AWP_IDX_ROUTE: next_rd = route;
         default: next_rd = 8'h00;
      endcase
   end

   // Every access is answered one cycle after it is presented.
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         waitrequest <= 1'b1;
         readdata <= 32'h00000000;
      end else begin
         waitrequest <= ~((read | write) & waitrequest);
         if (read & waitrequest) begin
            readdata <= {24'h000000, next_rd};
         end
      end
   end

   // Configuration registers.
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ploss <= `AWP_RST_PLOSS;
         grst <= `AWP_RST_GRST;
         pgc <= `AWP_RST_PGC;
         wro <= `AWP_RST_WRO;
         gev <= `AWP_RST_GEV;
         en1 <= 7'h00;
         en2 <= 6'h00;
         route <= `AWP_RST_ROUTE;
      end else begin
         if (hit(idx, `AWP_IDX_PLOSS, wr_lane)) begin
            ploss <= wbyte & `AWP_MSK_PLOSS; // [R21]
         end
         if (hit(idx, `AWP_IDX_GRST, wr_lane)) begin
            grst <= wbyte & `AWP_MSK_GRST; // [R1]
         end
         if (hit(idx, `AWP_IDX_PGC, wr_lane)) begin
            pgc <= wbyte & `AWP_MSK_PGC; // [R3] [R4] [R5] [R13]
         end
         if (hit(idx, `AWP_IDX_WRO, wr_lane)) begin
            wro <= wbyte & `AWP_MSK_WRO; // [R7] [R8] [R11] [R12]
         end
         if (hit(idx, `AWP_IDX_GEV, wr_lane)) begin
            gev <= wbyte;
         end
         if (hit(idx, `AWP_IDX_EN1, wr_lane)) begin
            en1 <= wbyte[6:0]; // [R16]
         end
         if (hit(idx, `AWP_IDX_EN2, wr_lane)) begin
            en2 <= wbyte[5:0]; // [R17]
         end
         if (hit(idx, `AWP_IDX_ROUTE, wr_lane)) begin
            route <= wbyte & `AWP_MSK_ROUTE; // [R18] [R19]
         end
      end
   end

   // Status flags: a new event in the clearing cycle keeps its flag set.
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st1 <= 7'h00;
         st2 <= 6'h00;
      end else begin
         if (hit(idx, `AWP_IDX_ST1, wr_lane)) begin
            st1 <= (st1 & ~wbyte[6:0]) | event_src_one; // [R14]
         end else begin
            st1 <= st1 | event_src_one; // [R14]
         end
         if (hit(idx, `AWP_IDX_ST2, wr_lane)) begin
            st2 <= (st2 & ~wbyte[5:0]) | event_src_two; // [R15]
         end else begin
            st2 <= st2 | event_src_two; // [R15]
         end
      end
   end

   // Write-one strobes; the stored bits stay zero so they read back as 0.
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         retrig <= 1'b0;
         case_open_clear <= 1'b0;
      end else begin
         retrig <= hit(idx, `AWP_IDX_PGC, wr_lane)
            & wbyte[`AWP_PGC_TRIG]; // [R6]
         case_open_clear <= hit(idx, `AWP_IDX_PGC, wr_lane)
            & wbyte[`AWP_PGC_CASECLR]; // [R2]
      end
   end

   // Power-good sequencer. Losing the low-power stage drops both
   // stages at once; only the rising edges are delayed.
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pg_state <= PG_OFF;
         pg_cnt <= 26'h0000000;
         power_good_first_stage <= 1'b0;
         power_good_out <= 1'b0;
      end else if (!power_good_low_stage) begin
         pg_state <= PG_OFF;
         pg_cnt <= 26'h0000000;
         power_good_first_stage <= 1'b0;
         power_good_out <= 1'b0;
      end else begin
         case (pg_state)
            PG_OFF: begin
               if (pgc[`AWP_PGC_ST1FAST]) begin
                  pg_cnt <= P_ST1_FAST[25:0]; // [R4]
               end else begin
                  pg_cnt <= P_ST1_SLOW[25:0]; // [R4]
               end
               pg_state <= PG_ST1;
            end
            PG_ST1: begin
               if (pg_cnt == 26'h0000000) begin
                  power_good_first_stage <= 1'b1; // [R4]
                  pg_cnt <= st2_len(
                     pgc[`AWP_PGC_DEL_HI:`AWP_PGC_DEL_LO]); // [R5]
                  pg_state <= PG_ST2;
               end else begin
                  pg_cnt <= pg_cnt - 26'h0000001;
               end
            end
            PG_ST2: begin
               if (pg_cnt == 26'h0000000) begin
                  power_good_out <= 1'b1; // [R5]
                  pg_state <= PG_ON;
               end else begin
                  pg_cnt <= pg_cnt - 26'h0000001;
               end
            end
            PG_ON: begin
               if (retrig) begin
                  // The output goes low for at least one cycle even
                  // when no second-stage delay is selected.
                  power_good_out <= 1'b0; // [R6]
                  pg_cnt <= st2_len(
                     pgc[`AWP_PGC_DEL_HI:`AWP_PGC_DEL_LO]); // [R6]
                  pg_state <= PG_ST2;
               end
            end
            default: begin
               pg_state <= PG_OFF;
            end
         endcase
      end
   end

   // Decide whether the system should come back on after power loss.
   always @* begin
      case (ploss[`AWP_PL_HI:`AWP_PL_LO])
         `AWP_PL_OFF: loss_on = 1'b0; // [R21]
         `AWP_PL_ON: loss_on = 1'b1; // [R21]
         `AWP_PL_PRIOR: loss_on = state_before_loss; // [R21]
         default: loss_on = ~pgc[`AWP_PGC_LAST]; // [R3] [R21]
      endcase
   end

   // Rising edges of the routed GPIO event levels.
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : gp_edge
         assign gpio_rise[g] = gpio_event[g] & ~gpio_prev[g];
      end
   endgenerate

   always @* begin
      pb_start = (power_return & wro[`AWP_WRO_LPULSE] & loss_on) // [R10]
         | (os_wake_key & keyboard_wake_enable
            & wro[`AWP_WRO_OSKEY]) // [R9]
         | (|(gpio_rise & route[6:4])); // [R18]
   end

   // Power-button pulse. A trigger during a pulse is merged into it.
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         gpio_prev <= 3'b000;
         pb_cnt <= 26'h0000000;
         power_button_out_n <= 1'b1;
      end else begin
         gpio_prev <= gpio_event;
         if (power_button_out_n) begin
            if (pb_start) begin
               power_button_out_n <= 1'b0; // [R10]
               pb_cnt <= P_PULSE[25:0] - 26'h0000001;
            end
         end else if (pb_cnt == 26'h0000000) begin
            power_button_out_n <= 1'b1;
         end else begin
            pb_cnt <= pb_cnt - 26'h0000001;
         end
      end
   end

   // Event pin and derived control outputs.
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pme_out_n <= 1'b1;
         mouse_combo_key_c <= 1'b0;
         key_set_three_enable <= 1'b0;
         key_set_two_enable <= 1'b0;
         watchdog_reset_n <= 1'b0;
         hw_monitor_reset_n <= 1'b0;
         gpio_group_reset_n <= 1'b0;
      end else begin
         pme_out_n <= ~(gev[`AWP_GEV_EN]
            & (|(st1 & en1) | |(st2 & en2)
               | |(gpio_event & route[2:0]))); // [R20] [R19]
         mouse_combo_key_c <= pgc[`AWP_PGC_MCOMBO]; // [R13]
         key_set_three_enable <= wro[`AWP_WRO_KS3]; // [R7]
         key_set_two_enable <= wro[`AWP_WRO_KS2]; // [R8]
         if (wro[`AWP_WRO_WDTSRC]) begin
            watchdog_reset_n <= power_good_out; // [R11]
         end else begin
            watchdog_reset_n <= lpc_reset_n; // [R11]
         end
         if (wro[`AWP_WRO_HMSRC]) begin
            hw_monitor_reset_n <= lpc_reset_n; // [R12]
         end else begin
            hw_monitor_reset_n <= power_good_out; // [R12]
         end
         if (grst[`AWP_GRST_G25]) begin
            gpio_group_reset_n <= resume_well_reset_n; // [R1]
         end else begin
            gpio_group_reset_n <= lpc_reset_n; // [R1]
         end
      end
   end

endmodule

// ### verilog/awpme_unused_guard.v
`timescale 1ns/10ps
// Holds no logic; the whole block lives in awpme_ctrl.v.

// ### bench/awpme_ctrl_assertions.sv
// Temporal checks on the ports of the ACPI wake and event block.
// Assumes the bench's shortened counts: first stage at least 30 cycles.
`timescale 1ns/10ps
module awpme_checker #(
   parameter [31:0] P_PULSE = 32'd20
) (
   input wire sys_clk,
   input wire arst_n,
   input wire [9:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [3:0] byteenable,
   input wire waitrequest,
   input wire power_good_low_stage,
   input wire lpc_reset_n,
   input wire resume_well_reset_n,
   input wire [6:0] event_src_one,
   input wire [5:0] event_src_two,
   input wire [2:0] gpio_event,
   input wire power_good_first_stage,
   input wire power_good_out,
   input wire power_button_out_n,
   input wire pme_out_n,
   input wire case_open_clear,
   input wire key_set_three_enable,
   input wire key_set_two_enable,
   input wire gpio_group_reset_n
);
   reg [31:0] low_cnt;
   wire wr_take = write && !waitrequest && byteenable[0];
   wire any_src = (|event_src_one) || (|event_src_two) || (|gpio_event)
      || write;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);
   // Counts the low samples of the button output so its width is known.
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         low_cnt <= 32'h0;
      end else if (power_button_out_n) begin
         low_cnt <= 32'h0;
      end else begin
         low_cnt <= low_cnt + 32'h1;
      end
   end
   sequence bus_take;
      (read || write) && waitrequest;
   endsequence
   sequence bus_answer;
      !waitrequest ##1 waitrequest;
   endsequence
   bus_answer_a: assert property (bus_take |=> bus_answer)
      else $error("bus answer not one cycle after request");
   case_pulse_a: assert property (case_open_clear |->
      $past(wr_take && address[9:2] == 8'he6 && writedata[5])
      ##1 !case_open_clear) else $error("case clear strobe wrong");
   first_stage_a: assert property ($rose(power_good_first_stage) |->
      power_good_low_stage && $past(power_good_low_stage, 29))
      else $error("first stage rose too early");
   final_follow_a: assert property (power_good_out |->
      power_good_first_stage) else $error("final stage ahead of first");
   low_drop_a: assert property ($fell(power_good_low_stage) |=>
      !power_good_first_stage && !power_good_out)
      else $error("power good not dropped");
   button_width_a: assert property ($rose(power_button_out_n) |->
      low_cnt == P_PULSE) else $error("button pulse width wrong");
   key_sets_a: assert property ($changed({key_set_three_enable,
      key_set_two_enable}) |-> $past(wr_take && address[9:2] == 8'he7, 2))
      else $error("key set enable changed without write");
   grp_reset_a: assert property ($past(arst_n) |->
      gpio_group_reset_n == $past(lpc_reset_n)
      || gpio_group_reset_n == $past(resume_well_reset_n))
      else $error("group reset follows no source");
   pme_cause_a: assert property ($fell(pme_out_n) |->
      $past(any_src) || $past(any_src, 2)) else $error("event pin uncaused");
endmodule
bind awpme_ctrl awpme_checker #(.P_PULSE(P_PULSE)) chk (.*);

// ### bench/awpme_button_model.sv
// Power-button side model: counts presses and keeps the last width.
// Assumes the button output is synchronous to sys_clk.
`timescale 1ns/10ps
module awpme_button_model (
   input wire sys_clk,
   input wire arst_n,
   input wire power_button_out_n,
   output reg [7:0] press_count,
   output reg [7:0] last_width
);
   reg [7:0] width;
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         press_count <= 8'h00;
         last_width <= 8'h00;
         width <= 8'h00;
      end else if (!power_button_out_n) begin
         width <= width + 8'h01;
      end else if (width != 8'h00) begin
         press_count <= press_count + 8'h01;
         last_width <= width;
         width <= 8'h00;
      end
   end
endmodule

// ### bench/tb.sv
// Self-checking bench for the ACPI wake and event block.
// Assumes shortened delay parameters; one cycle is 8 ns.
`timescale 1ns/10ps
module tb;
   localparam [31:0] PULSE = 32'd20;
   localparam [71:0] IDX = {8'he6, 8'he7, 8'hf2, 8'hf3, 8'hf4, 8'hf6,
      8'hf7, 8'hfe, 8'h10};
   localparam [71:0] RSTV = {8'h1c, 8'h00, 8'h3e, 48'h0};
   localparam [71:0] WRV = {8'h9e, 8'hf9, 8'hff, 16'h0, 8'h7f, 8'h3f,
      8'h77, 8'h00};
   reg sys_clk = 1'b0, arst_n = 1'b0, read = 1'b0, write = 1'b0;
   reg [9:0] address = 10'h000;
   reg [31:0] writedata = 32'h0;
   reg [3:0] byteenable = 4'hf;
   reg power_good_low_stage = 1'b0, power_return = 1'b0;
   reg os_wake_key = 1'b0, lpc_reset_n = 1'b1, resume_well_reset_n = 1'b1;
   reg state_before_loss = 1'b0, keyboard_wake_enable = 1'b0;
   reg [6:0] event_src_one = 7'h00;
   reg [5:0] event_src_two = 6'h00;
   reg [2:0] gpio_event = 3'h0;
   wire [31:0] readdata;
   wire waitrequest, power_good_first_stage, power_good_out, pme_out_n;
   wire power_button_out_n, case_open_clear, mouse_combo_key_c;
   wire key_set_three_enable, key_set_two_enable, watchdog_reset_n;
   wire hw_monitor_reset_n, gpio_group_reset_n;
   wire [7:0] press_count, last_width;
   integer errors = 0, checks_done = 0, case_seen = 0;
   awpme_ctrl #(.P_ST1_SLOW(32'd40), .P_ST1_FAST(32'd30), .P_ST2_32(32'd4),
      .P_ST2_96(32'd8), .P_ST2_250(32'd12), .P_PULSE(PULSE)) uut (
      .*
   );
   awpme_button_model btn (.sys_clk(sys_clk), .arst_n(arst_n),
      .power_button_out_n(power_button_out_n), .press_count(press_count),
      .last_width(last_width));
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end
   // The strobe lasts one cycle, so it is counted here rather than polled.
   always @(posedge sys_clk) begin
      if (case_open_clear === 1'b1) begin
         case_seen <= case_seen + 1;
      end
   end
   task automatic chk(input [31:0] got, input [31:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task automatic cyc(input integer n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic bus(input is_wr, input [7:0] ix, input [7:0] d,
      output [7:0] q);
      integer n;
      begin
         address <= {ix, 2'b00};
         read <= !is_wr;
         write <= is_wr;
         writedata <= {24'h0, d};
         n = 0;
         @(posedge sys_clk);
         while (waitrequest !== 1'b0 && n < 50) begin
            @(posedge sys_clk);
            n = n + 1;
         end
         chk(n < 50, 1);
         q = readdata[7:0];
         read <= 1'b0;
         write <= 1'b0;
         @(posedge sys_clk);
      end
   endtask
   task automatic reg_wr(input [7:0] ix, input [7:0] d);
      reg [7:0] q;
      bus(1'b1, ix, d, q);
   endtask
   task automatic reg_rd(input [7:0] ix, input [7:0] exp);
      reg [7:0] q;
      begin
         bus(1'b0, ix, 8'h00, q);
         chk(q, exp);
      end
   endtask
   task automatic t_regs;
      integer i;
      for (i = 0; i < 9; i = i + 1) begin
         reg_rd(IDX[8*i +: 8], RSTV[8*i +: 8]);
         reg_wr(IDX[8*i +: 8], 8'hff);
         reg_rd(IDX[8*i +: 8], WRV[8*i +: 8]);
      end
   endtask
   task automatic t_events;
      integer i;
      reg [7:0] b;
      begin
         reg_wr(8'hfe, 8'h00);
         reg_wr(8'hf2, 8'h01);
         for (i = 0; i < 13; i = i + 1) begin
            b = (i < 7) ? (8'h01 << i) : (8'h01 << (i - 7));
            if (i < 7) begin
               event_src_one <= b[6:0];
            end else begin
               event_src_two <= b[5:0];
            end
            @(posedge sys_clk);
            event_src_one <= 7'h00;
            event_src_two <= 6'h00;
            cyc(3);
            chk(pme_out_n, 1'b0);
            reg_rd((i < 7) ? 8'hf3 : 8'hf4, b);
            reg_wr((i < 7) ? 8'hf3 : 8'hf4, b);
            reg_rd((i < 7) ? 8'hf3 : 8'hf4, 8'h00);
            chk(pme_out_n, 1'b1);
         end
         reg_wr(8'hf7, 8'h3e);
         event_src_two <= 6'h01;
         @(posedge sys_clk);
         event_src_two <= 6'h00;
         cyc(3);
         chk(pme_out_n, 1'b1);
         reg_wr(8'hf2, 8'h00);
         reg_wr(8'hf7, 8'h3f);
         chk(pme_out_n, 1'b1);
         reg_wr(8'hf2, 8'h01);
         cyc(1);
         chk(pme_out_n, 1'b0);
         reg_wr(8'hf4, 8'h01);
      end
   endtask
   task automatic t_gpio;
      integer i;
      begin
         reg_wr(8'hfe, 8'h01);
         gpio_event <= 3'h1;
         cyc(3);
         chk(pme_out_n, 1'b0);
         for (i = 0; i < 3; i = i + 1) begin
            reg_wr(8'hfe, 8'h10 << i);
            gpio_event <= 3'h0;
            @(posedge sys_clk);
            gpio_event <= 3'h1 << i;
            cyc(PULSE + 6);
            chk(press_count, i + 1);
         end
         gpio_event <= 3'h0;
      end
   endtask
   task automatic t_pgood;
      integer d, n;
      begin
         for (d = 0; d < 4; d = d + 1) begin
            power_good_low_stage <= 1'b0;
            cyc(3);
            reg_wr(8'he6, {4'h1, d[0], d[1:0], 1'b0});
            power_good_low_stage <= 1'b1;
            n = 0;
            while (power_good_first_stage !== 1'b1 && n < 60) begin
               @(posedge sys_clk);
               n = n + 1;
            end
            chk(n >= (d[0] ? 30 : 40) && n <= (d[0] ? 35 : 45), 1);
            n = 0;
            while (power_good_out !== 1'b1 && n < 30) begin
               @(posedge sys_clk);
               n = n + 1;
            end
            chk(n, 4 * d + 1);
         end
         reg_wr(8'he6, 8'h13);
         n = 0;
         while (power_good_out !== 1'b0 && n < 5) begin
            @(posedge sys_clk);
            n = n + 1;
         end
         n = 0;
         while (power_good_out !== 1'b1 && n < 30) begin
            @(posedge sys_clk);
            n = n + 1;
         end
         chk(n, 5);
         reg_rd(8'he6, 8'h12);
      end
   endtask
   task automatic t_resets;
      begin
         reg_wr(8'he5, 8'h04);
         reg_wr(8'he7, 8'h08);
         lpc_reset_n <= 1'b0;
         cyc(3);
         chk(gpio_group_reset_n, 1'b1);
         chk(watchdog_reset_n, 1'b1);
         chk(hw_monitor_reset_n, 1'b1);
         resume_well_reset_n <= 1'b0;
         cyc(3);
         chk(gpio_group_reset_n, 1'b0);
         resume_well_reset_n <= 1'b1;
         lpc_reset_n <= 1'b1;
         reg_wr(8'he5, 8'h00);
         reg_wr(8'he7, 8'h01);
         lpc_reset_n <= 1'b0;
         cyc(3);
         chk({gpio_group_reset_n, watchdog_reset_n, hw_monitor_reset_n},
            0);
         lpc_reset_n <= 1'b1;
      end
   endtask
   task automatic t_wake;
      integer p, n0;
      begin
         keyboard_wake_enable <= 1'b1;
         reg_wr(8'he7, 8'h20);
         n0 = press_count;
         os_wake_key <= 1'b1;
         @(posedge sys_clk);
         os_wake_key <= 1'b0;
         cyc(PULSE + 6);
         chk(press_count, n0 + 1);
         reg_wr(8'he7, 8'h10);
         reg_wr(8'he6, 8'h10);
         state_before_loss <= 1'b1;
         for (p = 0; p < 4; p = p + 1) begin
            reg_wr(8'he4, {1'b0, p[1:0], 5'h00});
            n0 = press_count;
            power_return <= 1'b1;
            @(posedge sys_clk);
            power_return <= 1'b0;
            cyc(PULSE + 6);
            chk(press_count, n0 + ((p == 1 || p == 2) ? 1 : 0));
            chk(last_width, PULSE);
         end
      end
   endtask
   task automatic t_keys;
      integer n0;
      begin
         n0 = case_seen;
         reg_wr(8'he6, 8'hb0);
         cyc(1);
         chk(case_seen, n0 + 1);
         chk(mouse_combo_key_c, 1'b1);
         reg_rd(8'he6, 8'h90);
         reg_wr(8'he7, 8'hc0);
         cyc(1);
         chk({key_set_three_enable, key_set_two_enable}, 3);
         byteenable <= 4'he;
         reg_wr(8'he7, 8'h00);
         byteenable <= 4'hf;
         reg_rd(8'he7, 8'hc0);
      end
   endtask
   task automatic stop_test;
      begin
         if (errors == 0 && checks_done > 0) begin
            $display("verification passed");
         end else begin
            $display("verification failed");
         end
         $finish;
      end
   endtask
   initial begin
      repeat (12) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      t_regs;
      t_events;
      t_gpio;
      t_pgood;
      t_resets;
      t_wake;
      t_keys;
      stop_test;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      errors = errors + 1;
      stop_test;
   end
endmodule
